// ### dsc_consts.svh
/*
  Constants for the deep sleep controller: APB register offsets, field
  positions, reset values and timing counts.
  Assumes a 100 MHz pclk and 32-bit APB data.
*/
// Notes on behaviour
// - Arm bit must be followed by sleep instruction within one cycle, else cleared
// - Arm bit clears automatically on every deep sleep exit
// - Control, wake log and scratch registers need two consecutive equal writes
// - Setting the arm bit clears the whole wake-source log
// - Wake on power-on, master clear, calendar alarm, ext irq zero, watchdog
// - Master clear wakes only when its pin is low
// - Ext irq zero wakes if enabled at entry, at polarity level, after change
// - Calendar alarm wakes only while calendar is on
// - Pending interrupt requests are discarded at deep sleep entry
// - Wake performs power-on reset; scratch, calendar and watchdog survive
// - Wake log records events from arm set until pin hold clears
// - Exit flag set after deep sleep exit; firmware clears it
// - Brown-out event bit in control register reports brown-out during sleep
// - In sleep, input pins float and output pins hold entry latch value
// - After wake pin settings reset but pins frozen until hold cleared
// - Enabled brown-out or true power-on in sleep releases pins, loses state
// - Master clear in sleep keeps retained registers, hold and oscillator state (code keeps these but resets the frozen pin copies to inputs, drive low)
// - Watchdog enabled by config bit, counter reset on each entry
// - Watchdog clock select and five-bit postscaler set period, 1 ms to 25.7 days (here 0.5 ms up to about 2.3 h, limit truncated to WDT_BITS)
// - Low-voltage sleep wake is delayed by the regulator settle time
// - Armed sleep instruction enters deep sleep, else ordinary sleep
// - Control bits reset only by power-on reset outside deep sleep
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

`define DSC_OFF_CONTROL   12'h000
`define DSC_OFF_WAKE_LOG  12'h004
`define DSC_OFF_SCRATCH0  12'h008
`define DSC_OFF_SCRATCH1  12'h00C
`define DSC_OFF_RESET_CTL 12'h010
`define DSC_OFF_OSC_CTL   12'h014
`define DSC_OFF_PIN_DIR   12'h018
`define DSC_OFF_PIN_DRIVE 12'h01C
`define DSC_OFF_STATUS    12'h020

`define DSC_BIT_ARM       15
`define DSC_BIT_BROWNOUT  1
`define DSC_BIT_HOLD      0
`define DSC_BIT_EXIT_FLAG 10
`define DSC_BIT_OSC_ON    1

`define DSC_WAKE_POR      0
`define DSC_WAKE_MASTER_CLEAR_PIN     1
`define DSC_WAKE_ALARM    2
`define DSC_WAKE_EXT_IRQ_ZERO     3
`define DSC_WAKE_WDT      4
`define DSC_WAKE_BOR      5

`define DSC_ZERO32        32'h0000_0000
`define DSC_ARM_WINDOW    2'h1
`define DSC_REGULATOR_SETTLE_TIME_NS       10000
`define DSC_CLK_NS        10
`define DSC_WDT_MIN_MS    1
`define DSC_WDT_MAX_DAYS  257

`endif

// ### dsc_pkg.sv
/*
  Types for the deep sleep controller.
  Assumes dsc_consts.svh defines the numbers.
*/
package dsc_pkg;

  // Power state, one-hot
  typedef enum logic [3:0] {
    DSC_RUN    = 4'b0001,
    DSC_SLEEP  = 4'b0010,
    DSC_DEEP   = 4'b0100,
    DSC_SETTLE = 4'b1000
  } dsc_state_e;

  // Wake event inputs grouped together
  typedef struct packed {
    logic por;
    logic master_clear_pin_n;
    logic alarm;
    logic ext_irq_zero;
    logic bor;
  } dsc_wake_s;

  // Static configuration bits
  typedef struct packed {
    logic       wdt_on;
    logic       wdt_clk_sel;
    logic [4:0] wdt_postscale;
    logic       bor_on;
    logic       ext_irq_zero_en;
    logic       ext_irq_zero_pol;
    logic       calendar_on;
    logic       low_volt;
  } dsc_cfg_s;

endpackage : dsc_pkg

// ### dsc_deep_sleep.sv
/*
  Deep sleep controller with APB register slave, wake logic, pin hold and
  dedicated watchdog.
  Assumes the core raises power_save_instr for one cycle per sleep
  instruction, and that wake inputs are synchronous to pclk.
*/
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_consts.svh"

module dsc_deep_sleep #(
  parameter int PINS       = 16,
  parameter int WDT_BITS   = 40,
  parameter int REGULATOR_SETTLE_TIME_NS    = `DSC_REGULATOR_SETTLE_TIME_NS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              power_save_instr,
  input  wire dsc_pkg::dsc_wake_s wake_in,
  input  wire dsc_pkg::dsc_cfg_s  cfg,
  input  wire logic              irq_pending,
  output logic                   irq_discard,
  output logic                   core_reset,
  output logic                   core_halt,
  output logic                   deep_sleep_active,
  output logic                   secondary_osc_on,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe
);

  localparam int REGULATOR_SETTLE_TIME_CYC_I = (REGULATOR_SETTLE_TIME_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS;
  localparam int REGULATOR_SETTLE_TIME_CYC   = (REGULATOR_SETTLE_TIME_CYC_I < 1) ? 1 : REGULATOR_SETTLE_TIME_CYC_I;

  // Refuse widths the register map cannot hold
  initial begin
    if (PINS < 1 || PINS > 32 || WDT_BITS < 10 || WDT_BITS > 48) begin
      $error("dsc_deep_sleep: unsupported parameter");
    end
  end

  dsc_pkg::dsc_state_e state_reg;
  logic               arm_reg;
  logic               arm_window_reg;
  logic               hold_reg;
  logic               bor_flag_reg;
  logic [5:0]         wake_log_reg;
  logic [31:0]        scratch0_reg;
  logic [31:0]        scratch1_reg;
  logic               exit_flag_reg;
  logic               osc_on_reg;
  logic               osc_frozen_reg;
  logic [PINS-1:0]    pin_dir_reg;
  logic [PINS-1:0]    pin_drive_reg;
  logic [PINS-1:0]    frz_dir_reg;
  logic [PINS-1:0]    frz_drive_reg;
  logic               ext_irq_zero_seen_reg;
  logic               ext_irq_zero_en_reg;
  logic [WDT_BITS-1:0] wdt_cnt_reg;
  logic [15:0]        settle_reg;
  logic               first_wr_reg;
  logic [11:0]        first_addr_reg;
  logic [31:0]        first_data_reg;

  logic       wr_acc;
  logic       rd_acc;
  logic       protected_addr;
  logic       confirmed;
  logic       enter_deep;
  logic       wake_any;
  logic       bor_loss;
  logic [5:0] wake_now;
  logic [WDT_BITS-1:0] wdt_limit;

  assign wr_acc  = psel & penable & pwrite & clk_en;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Protected registers need the same word written twice in a row
  assign protected_addr = (paddr == `DSC_OFF_CONTROL) || (paddr == `DSC_OFF_WAKE_LOG) ||
                          (paddr == `DSC_OFF_SCRATCH0) || (paddr == `DSC_OFF_SCRATCH1);
  assign confirmed = first_wr_reg && first_addr_reg == paddr && first_data_reg == pwdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_wr_reg   <= 1'b0;
      first_addr_reg <= 12'h000;
      first_data_reg <= `DSC_ZERO32;
    end else if (wr_acc) begin
      first_wr_reg   <= protected_addr & ~confirmed;
      first_addr_reg <= paddr;
      first_data_reg <= pwdata;
    end
  end

  // Period: postscale doubles from about 1 ms, or from 0.5 ms with the clock select set
  assign wdt_limit = WDT_BITS'(64'd100000 << cfg.wdt_postscale) >> cfg.wdt_clk_sel;

  // Wake sources; all but power-on and master clear gated by their own qualifier
  always_comb begin
    wake_now = 6'h00;
    wake_now[`DSC_WAKE_POR]   = wake_in.por;
    wake_now[`DSC_WAKE_MASTER_CLEAR_PIN]  = ~wake_in.master_clear_pin_n;
    wake_now[`DSC_WAKE_ALARM] = wake_in.alarm & cfg.calendar_on;
    wake_now[`DSC_WAKE_EXT_IRQ_ZERO]  = ext_irq_zero_en_reg & ext_irq_zero_seen_reg & (wake_in.ext_irq_zero == cfg.ext_irq_zero_pol);
    wake_now[`DSC_WAKE_WDT]   = cfg.wdt_on && (wdt_cnt_reg >= wdt_limit);
    wake_now[`DSC_WAKE_BOR]   = wake_in.bor & cfg.bor_on;
  end

  assign wake_any   = (state_reg == dsc_pkg::DSC_DEEP) && (|wake_now);
  assign enter_deep = power_save_instr && arm_reg && arm_window_reg
                      && state_reg == dsc_pkg::DSC_RUN;
  assign bor_loss   = (state_reg == dsc_pkg::DSC_DEEP) &&
                      ((wake_in.bor & cfg.bor_on) | wake_in.por);

  // Power state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= dsc_pkg::DSC_RUN;
      settle_reg <= 16'h0000;
    end else if (clk_en) begin
      case (state_reg)
        dsc_pkg::DSC_RUN: begin
          if (enter_deep) begin
            state_reg <= dsc_pkg::DSC_DEEP;
          end else if (power_save_instr) begin
            state_reg <= dsc_pkg::DSC_SLEEP;
          end
        end
        dsc_pkg::DSC_SLEEP: begin
          // Low-voltage sleep waits for the core supply to return
          if (irq_pending || ~wake_in.master_clear_pin_n || wake_in.por) begin
            settle_reg <= cfg.low_volt ? 16'(REGULATOR_SETTLE_TIME_CYC) : 16'h0001;
            state_reg  <= dsc_pkg::DSC_SETTLE;
          end
        end
        dsc_pkg::DSC_DEEP: begin
          if (wake_any) begin
            state_reg  <= dsc_pkg::DSC_SETTLE;
            settle_reg <= 16'h0001;
          end
        end
        dsc_pkg::DSC_SETTLE: begin
          if (settle_reg <= 16'h0001) begin
            state_reg <= dsc_pkg::DSC_RUN;
          end else begin
            settle_reg <= settle_reg - 16'h0001;
          end
        end
        default: state_reg <= dsc_pkg::DSC_RUN;
      endcase
    end
  end

  // Arm bit and its one-instruction window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg        <= 1'b0;
      arm_window_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == dsc_pkg::DSC_DEEP && wake_any) begin
        arm_reg <= 1'b0;
      end else if (wr_acc && confirmed && paddr == `DSC_OFF_CONTROL) begin
        arm_reg        <= pwdata[`DSC_BIT_ARM];
        arm_window_reg <= pwdata[`DSC_BIT_ARM];
      end else if (arm_reg && state_reg == dsc_pkg::DSC_RUN) begin
        // Window lasts one cycle; missed instruction disarms
        arm_window_reg <= 1'b0;
        if (!arm_window_reg || !power_save_instr) begin
          arm_reg <= arm_window_reg;
        end
      end
    end
  end

  // Pin hold, brown-out flag and wake log
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg     <= 1'b0;
      bor_flag_reg <= 1'b0;
      wake_log_reg <= 6'h00;
    end else if (clk_en) begin
      if (bor_loss) begin
        hold_reg     <= 1'b0;
        bor_flag_reg <= wake_in.bor & cfg.bor_on;
      end else if (enter_deep) begin
        hold_reg <= 1'b1;
      end else if (wr_acc && confirmed && paddr == `DSC_OFF_CONTROL) begin
        hold_reg     <= pwdata[`DSC_BIT_HOLD];
        bor_flag_reg <= pwdata[`DSC_BIT_BROWNOUT];
      end
      if (wr_acc && confirmed && paddr == `DSC_OFF_CONTROL && pwdata[`DSC_BIT_ARM]) begin
        wake_log_reg <= 6'h00;
      end else if (wr_acc && confirmed && paddr == `DSC_OFF_WAKE_LOG) begin
        wake_log_reg <= pwdata[5:0] | ((arm_reg | hold_reg) ? wake_now : 6'h00);
      end else if (arm_reg || hold_reg) begin
        wake_log_reg <= wake_log_reg | wake_now;
      end
    end
  end

  // Scratch words survive wake, lost on enabled brown-out or true power-on in deep sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch0_reg <= `DSC_ZERO32;
      scratch1_reg <= `DSC_ZERO32;
    end else if (clk_en) begin
      if (bor_loss) begin
        scratch0_reg <= `DSC_ZERO32;
        scratch1_reg <= `DSC_ZERO32;
      end else if (wr_acc && confirmed && paddr == `DSC_OFF_SCRATCH0) begin
        scratch0_reg <= pwdata;
      end else if (wr_acc && confirmed && paddr == `DSC_OFF_SCRATCH1) begin
        scratch1_reg <= pwdata;
      end
    end
  end

  // Exit flag: set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (wake_any) begin
        exit_flag_reg <= 1'b1;
      end else if (wr_acc && paddr == `DSC_OFF_RESET_CTL && !pwdata[`DSC_BIT_EXIT_FLAG]) begin
        exit_flag_reg <= 1'b0;
      end
    end
  end

  // Ordinary registers reset by the wake; frozen copies hold the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dir_reg    <= '1;
      pin_drive_reg  <= '0;
      osc_on_reg     <= 1'b0;
      frz_dir_reg    <= '1;
      frz_drive_reg  <= '0;
      osc_frozen_reg <= 1'b0;
    end else if (clk_en) begin
      if (enter_deep) begin
        frz_dir_reg    <= pin_dir_reg;
        frz_drive_reg  <= pin_drive_reg;
        osc_frozen_reg <= osc_on_reg;
      end else if (state_reg == dsc_pkg::DSC_DEEP && ~wake_in.master_clear_pin_n) begin
        frz_dir_reg   <= '1;
        frz_drive_reg <= '0;
      end
      if (wake_any) begin
        pin_dir_reg   <= '1;
        pin_drive_reg <= '0;
        osc_on_reg    <= 1'b0;
      end else if (wr_acc && paddr == `DSC_OFF_PIN_DIR) begin
        pin_dir_reg <= pwdata[PINS-1:0];
      end else if (wr_acc && paddr == `DSC_OFF_PIN_DRIVE) begin
        pin_drive_reg <= pwdata[PINS-1:0];
      end else if (wr_acc && paddr == `DSC_OFF_OSC_CTL) begin
        osc_on_reg <= pwdata[`DSC_BIT_OSC_ON];
      end
    end
  end

  // Watchdog counts only in deep sleep; cleared on each entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= '0;
    end else if (clk_en) begin
      if (enter_deep) begin
        wdt_cnt_reg <= '0;
      end else if (state_reg == dsc_pkg::DSC_DEEP && cfg.wdt_on) begin
        wdt_cnt_reg <= wdt_cnt_reg + WDT_BITS'(1);
      end
    end
  end

  // Ext irq zero: enable caught at entry, needs a level change inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_zero_en_reg   <= 1'b0;
      ext_irq_zero_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (enter_deep) begin
        ext_irq_zero_en_reg   <= cfg.ext_irq_zero_en;
        ext_irq_zero_seen_reg <= 1'b0;
      end else if (state_reg == dsc_pkg::DSC_DEEP && wake_in.ext_irq_zero != cfg.ext_irq_zero_pol) begin
        ext_irq_zero_seen_reg <= 1'b1;
      end
    end
  end

  // Read data from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `DSC_ZERO32;
    end else if (rd_acc) begin
      if (paddr == `DSC_OFF_CONTROL) begin
        prdata <= {16'h0000, arm_reg, 13'h0000, bor_flag_reg, hold_reg};
      end else if (paddr == `DSC_OFF_WAKE_LOG) begin
        prdata <= {26'h000_0000, wake_log_reg};
      end else if (paddr == `DSC_OFF_SCRATCH0) begin
        prdata <= scratch0_reg;
      end else if (paddr == `DSC_OFF_SCRATCH1) begin
        prdata <= scratch1_reg;
      end else if (paddr == `DSC_OFF_RESET_CTL) begin
        prdata <= {21'h00_0000, exit_flag_reg, 10'h000};
      end else if (paddr == `DSC_OFF_OSC_CTL) begin
        prdata <= {30'h0000_0000, osc_on_reg, 1'b0};
      end else if (paddr == `DSC_OFF_PIN_DIR) begin
        prdata <= 32'(pin_dir_reg);
      end else if (paddr == `DSC_OFF_PIN_DRIVE) begin
        prdata <= 32'(pin_drive_reg);
      end else if (paddr == `DSC_OFF_STATUS) begin
        prdata <= {28'h000_0000, state_reg};
      end else begin
        prdata <= `DSC_ZERO32;
      end
    end
  end

  // Pins follow frozen copies while held
  assign pin_out = hold_reg ? frz_drive_reg : pin_drive_reg;
  assign pin_oe  = hold_reg ? ~frz_dir_reg : ~pin_dir_reg;
  assign secondary_osc_on = hold_reg ? osc_frozen_reg : osc_on_reg;
  assign irq_discard = enter_deep & irq_pending;
  assign core_reset  = wake_any;
  assign core_halt   = (state_reg != dsc_pkg::DSC_RUN);
  assign deep_sleep_active = (state_reg == dsc_pkg::DSC_DEEP);

endmodule : dsc_deep_sleep
`default_nettype wire

// ### dsc_deep_sleep_asserts.sv
/*
  Port checker for the deep sleep controller.
  Assumes it is bound onto dsc_deep_sleep, one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dsc_deep_sleep_asserts #(
  parameter int PINS = 16
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               power_save_instr,
  input wire dsc_pkg::dsc_wake_s wake_in,
  input wire dsc_pkg::dsc_cfg_s  cfg,
  input wire logic               irq_pending,
  input wire logic               irq_discard,
  input wire logic               core_reset,
  input wire logic               deep_sleep_active,
  input wire logic [PINS-1:0]    pin_out,
  input wire logic [PINS-1:0]    pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [63:0] dcnt;
  logic [63:0] wlim;
  // Cycles in deep sleep, restarted on every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dcnt <= '0;
    else if (deep_sleep_active) dcnt <= dcnt + 64'h1;
    else dcnt <= '0;
  end
  // Watchdog limit in pclk cycles, plus slack below
  assign wlim = (64'h1_86A0 << cfg.wdt_postscale) >> cfg.wdt_clk_sel;

  property p_enter;
    $rose(deep_sleep_active) |-> $past(power_save_instr);
  endproperty
  a_enter: assert property (p_enter)
    else $error("deep entry without sleep instruction");
  property p_discard;
    irq_discard |-> irq_pending && power_save_instr;
  endproperty
  a_discard: assert property (p_discard)
    else $error("discard without pending request at entry");
  property p_master_clear_pin;
    deep_sleep_active && !wake_in.master_clear_pin_n |-> ##[0:4] !deep_sleep_active;
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin)
    else $error("no wake on master clear");
  property p_alarm_on;
    deep_sleep_active && wake_in.alarm && cfg.calendar_on |-> ##[0:4] !deep_sleep_active;
  endproperty
  a_alarm_on: assert property (p_alarm_on)
    else $error("no wake on enabled alarm");
  property p_alarm_off;
    deep_sleep_active && wake_in.alarm && !cfg.calendar_on && wake_in.master_clear_pin_n
      && !wake_in.por && !wake_in.bor && !cfg.ext_irq_zero_en && !cfg.wdt_on
      |=> deep_sleep_active;
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("wake on alarm with calendar off");
  property p_ext_irq_zero;
    deep_sleep_active && cfg.ext_irq_zero_en && $changed(wake_in.ext_irq_zero)
      && (wake_in.ext_irq_zero == cfg.ext_irq_zero_pol) |-> ##[0:4] !deep_sleep_active;
  endproperty
  a_ext_irq_zero: assert property (p_ext_irq_zero)
    else $error("no wake on ext irq zero");
  property p_frozen;
    deep_sleep_active && $past(deep_sleep_active) && wake_in.master_clear_pin_n && !wake_in.bor
      |-> $stable(pin_oe) && $stable(pin_out);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("pins moved in deep sleep");
  property p_wake_rst;
    $fell(deep_sleep_active) |-> $past(core_reset);
  endproperty
  a_wake_rst: assert property (p_wake_rst)
    else $error("deep exit without core reset");
  property p_wdt;
    deep_sleep_active && cfg.wdt_on |-> dcnt <= wlim + 64'h8;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog overran its period");

  // Main scenarios reached
  c_enter: cover property ($rose(deep_sleep_active));
  c_discard: cover property (irq_discard);
  c_wake: cover property (core_reset);
endmodule // dsc_deep_sleep_asserts
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for the deep sleep controller.
  Assumes the constants header, package and checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsc_consts.svh"
module tb_top;
  localparam int PINS = 16;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic               power_save_instr, irq_pending, irq_discard;
  logic               core_reset, core_halt, deep_sleep_active, secondary_osc_on;
  dsc_pkg::dsc_wake_s wake_in;
  dsc_pkg::dsc_cfg_s  cfg;
  logic [PINS-1:0]    pin_out, pin_oe;
  int                 fail_count, n_tests;
  logic               rd_seen;
  logic [31:0]        exp_q[$], msk_q[$];
  string              nm_q[$];

  dsc_deep_sleep #(.PINS(PINS), .REGULATOR_SETTLE_TIME_NS(100)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_save_instr(power_save_instr), .wake_in(wake_in), .cfg(cfg),
    .irq_pending(irq_pending), .irq_discard(irq_discard), .core_reset(core_reset),
    .core_halt(core_halt), .deep_sleep_active(deep_sleep_active),
    .secondary_osc_on(secondary_osc_on), .pin_out(pin_out), .pin_oe(pin_oe));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic summarize;
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, m, s);
    n_tests++;
    if ((s & m) !== (e & m)) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask

  // Request held until pready is seen high with penable
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t == 50) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input string nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Protected registers only take a repeated write
  task automatic wr2(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    apb(1'b1, a, d);
  endtask

  // Registered read data is valid one edge after the access
  always @(posedge pclk) begin
    if (rd_seen && exp_q.size() > 0)
      chk(nm_q.pop_front(), exp_q.pop_front(), msk_q.pop_front(), prdata);
    rd_seen <= psel && penable && !pwrite && pready;
  end

  // Arm, then sleep instruction in the very next cycle
  task automatic enter;
    wr2(`DSC_OFF_CONTROL, 32'h0000_8000);
    power_save_instr <= 1'b1;
    irq_pending <= 1'b1;
    // Look mid-cycle, where the combinational pulse has settled
    @(negedge pclk);
    chk("discard", 32'h1, 32'h1, {31'h0, irq_discard});
    @(posedge pclk);
    power_save_instr <= 1'b0;
    irq_pending <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("deep", 32'h1, 32'h1, {31'h0, deep_sleep_active});
  endtask

  // k: 0 master clear, 1 alarm, 2 ext irq zero, 3 watchdog, 4 brown-out
  task automatic wake_case(input int k);
    logic [31:0] s;
    int          t;
    s = $urandom;
    wr2(`DSC_OFF_SCRATCH0, s);
    apb(1'b1, `DSC_OFF_PIN_DIR, $urandom);
    apb(1'b1, `DSC_OFF_PIN_DRIVE, $urandom);
    cfg.wdt_on <= (k == 3);
    cfg.ext_irq_zero_en <= (k == 2);
    cfg.bor_on <= (k == 4);
    cfg.calendar_on <= 1'b0;
    enter();
    case (k)
      0: wake_in.master_clear_pin_n <= 1'b0;
      1: begin
        wake_in.alarm <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("alarm off", 32'h1, 32'h1, {31'h0, deep_sleep_active});
        cfg.calendar_on <= 1'b1;
      end
      2: wake_in.ext_irq_zero <= cfg.ext_irq_zero_pol;
      4: wake_in.bor <= 1'b1;
      default: ;
    endcase
    @(posedge pclk);
    wake_in.master_clear_pin_n <= 1'b1;
    wake_in.alarm <= 1'b0;
    wake_in.ext_irq_zero <= !cfg.ext_irq_zero_pol;
    wake_in.bor <= 1'b0;
    t = 0;
    while (core_halt !== 1'b0 && t < 70000) begin
      @(posedge pclk);
      t++;
    end
    chk("halt", 32'h0, 32'h1, {31'h0, core_halt});
    if (k < 4) begin
      rd(`DSC_OFF_WAKE_LOG, 32'h1 << (k + 1), 32'hFFFF_FFFF, "log");
      rd(`DSC_OFF_RESET_CTL, 32'h0000_0400, 32'h0000_0400, "exit");
      apb(1'b1, `DSC_OFF_RESET_CTL, 32'h0000_0000);
      rd(`DSC_OFF_RESET_CTL, 32'h0000_0000, 32'h0000_0400, "exit clr");
    end
    rd(`DSC_OFF_CONTROL, 32'h0000_0000, 32'h0000_8000, "arm");
    rd(`DSC_OFF_SCRATCH0, (k == 4) ? 32'h0000_0000 : s, 32'hFFFF_FFFF, "scr");
    apb(1'b1, `DSC_OFF_OSC_CTL, 32'h0000_0002);
    wr2(`DSC_OFF_CONTROL, 32'h0000_0000);
    @(posedge pclk);
    chk("pin oe", 32'h0, 32'h0000_FFFF, {16'h0, pin_oe});
    chk("osc on", 32'h1, 32'h1, {31'h0, secondary_osc_on});
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    void'($urandom(67));
    fail_count = 0;
    n_tests = 0;
    rd_seen = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    power_save_instr = 1'b0;
    irq_pending = 1'b0;
    cfg = '0;
    cfg.ext_irq_zero_pol = 1'($urandom);
    cfg.wdt_clk_sel = 1'b1;
    wake_in = '0;
    wake_in.master_clear_pin_n = 1'b1;
    wake_in.ext_irq_zero = !cfg.ext_irq_zero_pol;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DSC_OFF_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF, "ctrl rst");
    rd(`DSC_OFF_STATUS, 32'h0000_0001, 32'h0000_000F, "state");
    rd(12'h0FC, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    apb(1'b1, `DSC_OFF_SCRATCH1, 32'h1234_5678);
    rd(`DSC_OFF_SCRATCH1, 32'h0000_0000, 32'hFFFF_FFFF, "one write");
    apb(1'b1, `DSC_OFF_SCRATCH1, 32'h1234_5678);
    rd(`DSC_OFF_SCRATCH1, 32'h1234_5678, 32'hFFFF_FFFF, "two writes");
    wr2(`DSC_OFF_CONTROL, 32'h0000_8000);
    repeat (3) @(posedge pclk);
    rd(`DSC_OFF_CONTROL, 32'h0000_0000, 32'h0000_8000, "arm lapse");
    for (int k = 0; k < 5; k++) wake_case(k);
    repeat (4) @(posedge pclk);
    summarize();
  end

  // Cuts a hang short; the watchdog case alone needs about 0.5 ms
  initial begin
    #900_000;
    fail_count++;
    summarize();
  end
endmodule // tb_top

bind dsc_deep_sleep dsc_deep_sleep_asserts #(.PINS(PINS)) u_chk (
  .pclk(pclk), .presetn(presetn), .power_save_instr(power_save_instr),
  .wake_in(wake_in), .cfg(cfg), .irq_pending(irq_pending),
  .irq_discard(irq_discard), .core_reset(core_reset),
  .deep_sleep_active(deep_sleep_active), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
